// >>> rtl/tsio_pkg.sv
// Constants, types and helpers shared by the timed serdes I/O port block
package tsio_pkg;

  // Structure
  localparam int NPORT  = 5;
  localparam int NCB    = 6;
  localparam int XFER_W = 32;
  localparam int CNT_W  = 16;
  localparam int NPIN   = 32;
  localparam int CHK_W  = 6;
  localparam int DIV_W  = 8;
  localparam int CTRL_W = 10;

  // Nominal rate of clock block zero; in this block it ticks every ref_clk
  localparam int REF_CLK_HZ_NOMINAL = 100_000_000;

  // Pins taken by the inter-chip link when it is enabled
  localparam logic [31:0] LINK_PIN_MASK = 32'h0000_0F00;

  // Register map (byte addresses)
  localparam logic [7:0] PORT_STRIDE = 8'h20;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_DATA    = 8'h04;
  localparam logic [7:0] OFS_STAT    = 8'h08;
  localparam logic [7:0] OFS_COUNT   = 8'h0C;
  localparam logic [7:0] OFS_TIME    = 8'h10;
  localparam logic [7:0] OFS_TSTAMP  = 8'h14;
  localparam logic [7:0] OFS_CMP     = 8'h18;
  localparam logic [7:0] OFS_LINK    = 8'hA0;
  localparam logic [7:0] OFS_CB_BASE = 8'hC0;

  // Status bit positions
  localparam int STAT_FULL  = 0;
  localparam int STAT_BUSY  = 1;
  localparam int STAT_ARMED = 2;

  // Clock block register field positions
  localparam int CB_DIV_LSB = 0;
  localparam int CB_SRC_BIT = 8;

  typedef enum logic [1:0] {
    TSIO_COND_NONE = 2'b00,
    TSIO_COND_EQ   = 2'b01,
    TSIO_COND_NEQ  = 2'b10,
    TSIO_COND_RSVD = 2'b11
  } tsio_cond_t;

  // Port control word: en bit 0, dir 1, open drain 2, cond 4:3, strobed 5, serial 6, clock block 9:7
  typedef struct packed {
    logic [2:0] clk_sel;
    logic       serial;
    logic       strobed;
    tsio_cond_t cond;
    logic       open_drain;
    logic       dir_out;
    logic       en;
  } tsio_ctrl_t;

  typedef struct packed {
    tsio_ctrl_t        ctrl;
    logic [XFER_W-1:0] shift;
    logic [XFER_W-1:0] xfer;
    logic [XFER_W-1:0] cmp;
    logic [XFER_W-1:0] outv;
    logic              full;
    logic [CHK_W-1:0]  chunk;
    logic              armed;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  due_time;
    logic [CNT_W-1:0]  tstamp;
  } tsio_port_t;

  typedef struct packed {
    logic             src_pin;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] cnt;
  } tsio_cb_t;

  localparam tsio_port_t PORT_RST = '0;
  localparam tsio_cb_t   CB_RST   = '0;

  function automatic int port_width(input int p);
    case (p)
      0:       return 1;
      1:       return 4;
      2:       return 8;
      3:       return 16;
      default: return 32;
    endcase
  endfunction

  function automatic logic [31:0] port_mask(input int p);
    return 32'hFFFF_FFFF >> (32 - port_width(p));
  endfunction

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

endpackage

// >>> rtl/tsio_port_top.sv
// Timed serdes I/O ports with shared pins, clock blocks and Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none

module tsio_port_top (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  // Avalon-MM slave
  input  wire logic [7:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  // Pins
  input  wire logic [tsio_pkg::NPIN-1:0]  pin_i,
  output logic      [tsio_pkg::NPIN-1:0]  pin_o,
  output logic      [tsio_pkg::NPIN-1:0]  pin_oe_n,
  output logic      [tsio_pkg::NPIN-1:0]  pin_pull_down,
  // Strobes
  input  wire logic [tsio_pkg::NPORT-1:0] input_qualify_strobe,
  output logic      [tsio_pkg::NPORT-1:0] output_qualify_strobe,
  // Scheduler events
  output logic      [tsio_pkg::NPORT-1:0] port_event
);

  // Pin and strobe synchronisers
  logic [tsio_pkg::NPIN-1:0]  pin_m_ff;
  logic [tsio_pkg::NPIN-1:0]  pin_s_ff;
  logic [tsio_pkg::NPIN-1:0]  nxt_pin_m;
  logic [tsio_pkg::NPIN-1:0]  nxt_pin_s;
  logic [tsio_pkg::NPORT-1:0] stb_m_ff;
  logic [tsio_pkg::NPORT-1:0] stb_s_ff;
  logic [tsio_pkg::NPORT-1:0] nxt_stb_m;
  logic [tsio_pkg::NPORT-1:0] nxt_stb_s;
  logic                       clkpin_d_ff;
  logic                       nxt_clkpin_d;

  // Bus state
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        link_en_ff;
  logic        nxt_link_en;

  // Port and clock block state
  tsio_pkg::tsio_port_t       port_ff     [tsio_pkg::NPORT];
  tsio_pkg::tsio_port_t       nxt_port    [tsio_pkg::NPORT];
  tsio_pkg::tsio_cb_t         cb_ff       [tsio_pkg::NCB];
  tsio_pkg::tsio_cb_t         nxt_cb      [tsio_pkg::NCB];
  logic [tsio_pkg::NPORT-1:0] ostb_ff;
  logic [tsio_pkg::NPORT-1:0] nxt_ostb;
  logic [tsio_pkg::NPORT-1:0] evt_ff;
  logic [tsio_pkg::NPORT-1:0] nxt_evt;

  logic [tsio_pkg::NCB-1:0]   cb_tick;
  logic [tsio_pkg::NPORT-1:0] port_live;
  logic                       wr_go;
  logic                       rd_go;
  logic [2:0]                 sel_port;
  logic [7:0]                 sel_ofs;
  logic                       sel_is_port;

  assign wr_go       = avs_write & ack_ff;
  assign rd_go       = avs_read & ack_ff;
  assign sel_port    = avs_address[7:5];
  assign sel_ofs     = {3'h0, avs_address[4:0]};
  assign sel_is_port = (avs_address < (tsio_pkg::PORT_STRIDE * 8'(tsio_pkg::NPORT)));

  // One wait cycle, then the access completes
  assign avs_waitrequest       = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata          = rdata_ff;
  assign output_qualify_strobe = ostb_ff;
  assign port_event            = evt_ff;

  // Synchronisers
  always_comb begin
    nxt_pin_m    = pin_i;
    nxt_pin_s    = pin_m_ff;
    nxt_stb_m    = input_qualify_strobe;
    nxt_stb_s    = stb_m_ff;
    nxt_clkpin_d = pin_s_ff[0];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_m_ff    <= '0;
      pin_s_ff    <= '0;
      stb_m_ff    <= '0;
      stb_s_ff    <= '0;
      clkpin_d_ff <= 1'b0;
    end else begin
      pin_m_ff    <= nxt_pin_m;
      pin_s_ff    <= nxt_pin_s;
      stb_m_ff    <= nxt_stb_m;
      stb_s_ff    <= nxt_stb_s;
      clkpin_d_ff <= nxt_clkpin_d;
    end
  end

  // Clock blocks
  always_comb begin
    logic clk_edge;
    clk_edge = pin_s_ff[0] & ~clkpin_d_ff;
    cb_tick  = '0;
    for (int b = 0; b < tsio_pkg::NCB; b++) begin
      nxt_cb[b] = cb_ff[b];
      if (b == 0) begin
        cb_tick[b] = 1'b1;
      end else if (cb_ff[b].src_pin) begin
        if (clk_edge) begin
          cb_tick[b]    = (cb_ff[b].cnt >= cb_ff[b].div);
          nxt_cb[b].cnt = cb_tick[b] ? '0 : cb_ff[b].cnt + 8'h01;
        end
      end else begin
        cb_tick[b]    = (cb_ff[b].cnt >= cb_ff[b].div);
        nxt_cb[b].cnt = cb_tick[b] ? '0 : cb_ff[b].cnt + 8'h01;
      end
      if (wr_go && b != 0 && avs_address == tsio_pkg::OFS_CB_BASE + 8'(4 * b)) begin
        if (avs_byteenable[0]) begin
          nxt_cb[b].div = avs_writedata[tsio_pkg::CB_DIV_LSB +: tsio_pkg::DIV_W];
        end
        if (avs_byteenable[1]) begin
          nxt_cb[b].src_pin = avs_writedata[tsio_pkg::CB_SRC_BIT];
        end
        nxt_cb[b].cnt = '0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int b = 0; b < tsio_pkg::NCB; b++) begin
      if (reset) begin
        cb_ff[b] <= tsio_pkg::CB_RST;
      end else begin
        cb_ff[b] <= nxt_cb[b];
      end
    end
  end

  // Port liveness: a port touching link pins is dropped while the link is on
  always_comb begin
    for (int p = 0; p < tsio_pkg::NPORT; p++) begin
      port_live[p] = port_ff[p].ctrl.en &
                     ~(link_en_ff & |(tsio_pkg::port_mask(p) & tsio_pkg::LINK_PIN_MASK));
    end
  end

  // Port transfer engines
  always_comb begin
    tsio_pkg::tsio_port_t ps;
    logic [31:0] m;
    logic [31:0] sample;
    logic [31:0] sh;
    logic        tick;
    logic        due;
    logic        hit;
    logic        qual;
    logic        here;
    int          w;
    int          nchk;
    ps       = tsio_pkg::PORT_RST;
    m        = '0;
    sample   = '0;
    sh       = '0;
    tick     = 1'b0;
    due      = 1'b0;
    hit      = 1'b0;
    qual     = 1'b0;
    here     = 1'b0;
    w        = 1;
    nchk     = 1;
    nxt_ostb = '0;
    nxt_evt  = '0;
    for (int p = 0; p < tsio_pkg::NPORT; p++) begin
      ps   = port_ff[p];
      w    = tsio_pkg::port_width(p);
      m    = tsio_pkg::port_mask(p);
      nchk = ps.ctrl.serial ? (tsio_pkg::XFER_W / w) : 1;
      here = sel_is_port && (sel_port == 3'(p));
      // Bus side first so that hardware sets below win over clears
      if (wr_go && here) begin
        unique case (sel_ofs)
          tsio_pkg::OFS_CTRL: begin
            ps.ctrl  = tsio_pkg::tsio_ctrl_t'(avs_writedata[tsio_pkg::CTRL_W-1:0]);
            ps.chunk = '0;
          end
          tsio_pkg::OFS_DATA: begin
            if (ps.ctrl.dir_out && !ps.full) begin
              ps.xfer = avs_writedata & tsio_pkg::be_mask(avs_byteenable);
              ps.full = 1'b1;
            end
          end
          tsio_pkg::OFS_COUNT: ps.cnt = avs_writedata[tsio_pkg::CNT_W-1:0];
          tsio_pkg::OFS_TIME: begin
            ps.due_time = avs_writedata[tsio_pkg::CNT_W-1:0];
            ps.armed    = 1'b1;
          end
          tsio_pkg::OFS_CMP: ps.cmp = (ps.cmp & ~tsio_pkg::be_mask(avs_byteenable)) |
                                      (avs_writedata & tsio_pkg::be_mask(avs_byteenable));
          default: ;
        endcase
      end
      if (rd_go && here && sel_ofs == tsio_pkg::OFS_DATA && !ps.ctrl.dir_out) begin
        ps.full = 1'b0;
      end
      tick = cb_tick[ps.ctrl.clk_sel] & port_live[p];
      due  = ~ps.armed | (port_ff[p].cnt == ps.due_time);
      if (tick) begin
        if (ps.ctrl.dir_out) begin
          if (ps.chunk != '0) begin
            ps.outv     = ps.shift & m;
            ps.shift    = ps.shift >> w;
            ps.chunk    = ps.chunk - 6'h01;
            nxt_ostb[p] = ps.ctrl.strobed;
          end else if (ps.full && due) begin
            ps.outv     = ps.xfer & m;
            ps.shift    = ps.xfer >> w;
            ps.chunk    = CHK_W_CAST(nchk - 1);
            ps.full     = 1'b0;
            ps.tstamp   = port_ff[p].cnt;
            ps.armed    = 1'b0;
            nxt_ostb[p] = ps.ctrl.strobed;
            nxt_evt[p]  = 1'b1;
          end
        end else begin
          sample = pin_s_ff & m;
          qual   = ~ps.ctrl.strobed | stb_s_ff[p];
          unique case (ps.ctrl.cond)
            tsio_pkg::TSIO_COND_EQ:  hit = (sample == (ps.cmp & m));
            tsio_pkg::TSIO_COND_NEQ: hit = (sample != (ps.cmp & m));
            default:                 hit = 1'b1;
          endcase
          if (qual && (ps.chunk != '0 || (due && hit))) begin
            sh = (ps.shift >> w) | (sample << (tsio_pkg::XFER_W - w));
            if (int'(ps.chunk) + 1 >= nchk) begin
              ps.xfer    = sh >> (tsio_pkg::XFER_W - w * nchk);
              ps.shift   = '0;
              ps.chunk   = '0;
              ps.full    = 1'b1;
              ps.tstamp  = port_ff[p].cnt;
              ps.armed   = 1'b0;
              nxt_evt[p] = 1'b1;
            end else begin
              ps.shift = sh;
              ps.chunk = ps.chunk + 6'h01;
            end
          end
        end
        ps.cnt = ps.cnt + 16'h0001;
      end
      nxt_port[p] = ps;
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int p = 0; p < tsio_pkg::NPORT; p++) begin
      if (reset) begin
        port_ff[p] <= tsio_pkg::PORT_RST;
      end else begin
        port_ff[p] <= nxt_port[p];
      end
    end
    if (reset) begin
      ostb_ff <= '0;
      evt_ff  <= '0;
    end else begin
      ostb_ff <= nxt_ostb;
      evt_ff  <= nxt_evt;
    end
  end

  function automatic logic [tsio_pkg::CHK_W-1:0] CHK_W_CAST(input int v);
    return v[tsio_pkg::CHK_W-1:0];
  endfunction

  // Pin ownership and drive
  always_comb begin
    logic       has;
    logic       drv;
    logic       val;
    logic       od;
    int         own;
    has = 1'b0;
    drv = 1'b0;
    val = 1'b0;
    od  = 1'b0;
    own = 0;
    for (int j = 0; j < tsio_pkg::NPIN; j++) begin
      has = 1'b0;
      own = 0;
      // Widest first, so the narrowest live port is the last to claim the pin
      for (int p = tsio_pkg::NPORT - 1; p >= 0; p--) begin
        if (port_live[p] && |(tsio_pkg::port_mask(p) & (32'h0000_0001 << j))) begin
          has = 1'b1;
          own = p;
        end
      end
      if (link_en_ff && tsio_pkg::LINK_PIN_MASK[j]) begin
        has = 1'b0;
      end
      drv = has & port_ff[own].ctrl.dir_out;
      val = port_ff[own].outv[j];
      od  = port_ff[own].ctrl.open_drain;
      if (od) begin
        pin_o[j]    = 1'b0;
        pin_oe_n[j] = ~(drv & ~val);
      end else begin
        pin_o[j]    = val;
        pin_oe_n[j] = ~drv;
      end
      pin_pull_down[j] = pin_oe_n[j];
    end
  end

  // Register bus
  always_comb begin
    tsio_pkg::tsio_port_t rp;
    rp          = port_ff[0];
    nxt_ack     = (avs_read | avs_write) & ~ack_ff;
    nxt_rdata   = rdata_ff;
    nxt_link_en = link_en_ff;
    if (wr_go && avs_address == tsio_pkg::OFS_LINK && avs_byteenable[0]) begin
      nxt_link_en = avs_writedata[0];
    end
    if (avs_read && !ack_ff) begin
      nxt_rdata = '0;
      if (sel_is_port) begin
        for (int p = 0; p < tsio_pkg::NPORT; p++) begin
          if (sel_port == 3'(p)) begin
            rp = port_ff[p];
          end
        end
        unique case (sel_ofs)
          tsio_pkg::OFS_CTRL:   nxt_rdata = {22'h0, rp.ctrl};
          tsio_pkg::OFS_DATA:   nxt_rdata = rp.xfer;
          tsio_pkg::OFS_STAT: begin
            nxt_rdata[tsio_pkg::STAT_FULL]  = rp.full;
            nxt_rdata[tsio_pkg::STAT_BUSY]  = (rp.chunk != '0);
            nxt_rdata[tsio_pkg::STAT_ARMED] = rp.armed;
          end
          tsio_pkg::OFS_COUNT:  nxt_rdata = {16'h0, rp.cnt};
          tsio_pkg::OFS_TIME:   nxt_rdata = {16'h0, rp.due_time};
          tsio_pkg::OFS_TSTAMP: nxt_rdata = {16'h0, rp.tstamp};
          tsio_pkg::OFS_CMP:    nxt_rdata = rp.cmp;
          default:              nxt_rdata = '0;
        endcase
      end else if (avs_address == tsio_pkg::OFS_LINK) begin
        nxt_rdata = {31'h0, link_en_ff};
      end else begin
        for (int b = 1; b < tsio_pkg::NCB; b++) begin
          if (avs_address == tsio_pkg::OFS_CB_BASE + 8'(4 * b)) begin
            nxt_rdata = {23'h0, cb_ff[b].src_pin, cb_ff[b].div};
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_ff     <= 1'b0;
      rdata_ff   <= '0;
      link_en_ff <= 1'b0;
    end else begin
      ack_ff     <= nxt_ack;
      rdata_ff   <= nxt_rdata;
      link_en_ff <= nxt_link_en;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/dummy_never.sv
// Empty source unit that holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> bench/tsio_port_props.sv
// Concurrent checks on the port block's bus and pin behaviour
`timescale 1ns/1ps
`default_nettype none
module tsio_port_props (
  // Clock and reset
  input wire logic                       ref_clk,
  input wire logic                       reset,
  // Bus
  input wire logic [7:0]                 avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_writedata,
  input wire logic [31:0]                avs_readdata,
  input wire logic                       avs_waitrequest,
  // Pins and events
  input wire logic [tsio_pkg::NPIN-1:0]  pin_oe_n,
  input wire logic [tsio_pkg::NPIN-1:0]  pin_pull_down,
  input wire logic [tsio_pkg::NPORT-1:0] output_qualify_strobe,
  input wire logic [tsio_pkg::NPORT-1:0] port_event
);
  logic [4:0] en_ff, nxt_en, drv_ff, nxt_drv;
  logic       link_ff, nxt_link, acc_w;

  // Shadow of enables, output directions and link enable
  assign acc_w = avs_write && !avs_waitrequest;
  always_comb begin
    nxt_en   = en_ff;
    nxt_drv  = drv_ff;
    nxt_link = link_ff;
    for (int p = 0; p < tsio_pkg::NPORT; p++) begin
      if (acc_w && avs_address == 8'(p * 32)) begin
        nxt_en[p]  = avs_writedata[0];
        nxt_drv[p] = avs_writedata[0] & avs_writedata[1];
      end
    end
    if (acc_w && avs_address == tsio_pkg::OFS_LINK) nxt_link = avs_writedata[0];
    if (reset) begin
      nxt_en   = '0;
      nxt_drv  = '0;
      nxt_link = 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    en_ff   <= nxt_en;
    drv_ff  <= nxt_drv;
    link_ff <= nxt_link;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'hFC |-> avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  a_rdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data changed without a read");
  a_pull_tracks: assert property (pin_pull_down == pin_oe_n)
    else $error("pull-down differs from undriven state");
  a_reset_release: assert property ($fell(reset) |-> (&pin_oe_n) && port_event == '0)
    else $error("pins driven or events at reset release");
  a_link_free: assert property (link_ff && $past(link_ff) |->
      (pin_oe_n & tsio_pkg::LINK_PIN_MASK) == tsio_pkg::LINK_PIN_MASK)
    else $error("link pins driven while link enabled");
  a_input_nodrive: assert property (drv_ff == '0 && $past(drv_ff) == '0 |-> &pin_oe_n)
    else $error("pin driven with no output port enabled");
  a_idle_quiet: assert property (en_ff == '0 && $past(en_ff) == '0 && $past(en_ff, 2) == '0 |->
      port_event == '0 && output_qualify_strobe == '0)
    else $error("event or strobe with all ports disabled");
endmodule

bind tsio_port_top tsio_port_props i_tsio_port_props (
  .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pin_oe_n(pin_oe_n), .pin_pull_down(pin_pull_down),
  .output_qualify_strobe(output_qualify_strobe), .port_event(port_event)
);
`default_nettype wire

// >>> bench/tsio_ext_model.sv
// External hardware on the pins: resolves levels, strobes and a pin clock
`timescale 1ns/1ps
`default_nettype none
module tsio_ext_model (
  // Clock
  input  wire logic        ref_clk,
  // Block side
  input  wire logic [31:0] pin_o,
  input  wire logic [31:0] pin_oe_n,
  input  wire logic [31:0] pin_pull_down,
  input  wire logic [4:0]  output_qualify_strobe,
  output logic      [31:0] pin_i,
  output logic      [4:0]  input_qualify_strobe,
  // Bench control
  input  wire logic [31:0] ext_val,
  input  wire logic [31:0] ext_drv,
  input  wire logic [4:0]  ext_stb,
  input  wire logic        ext_pullup,
  input  wire logic        clk_gen,
  output logic      [31:0] seen_word
);
  logic [1:0] div_ff = 2'h0;

  always_ff @(posedge ref_clk) div_ff <= div_ff + 2'h1;
  always_comb begin
    for (int k = 0; k < 32; k++) begin
      if (!pin_oe_n[k]) pin_i[k] = pin_o[k];
      else if (k == 0 && clk_gen) pin_i[k] = div_ff[1];
      else if (ext_drv[k]) pin_i[k] = ext_val[k];
      else if (ext_pullup) pin_i[k] = 1'b1;
      else pin_i[k] = pin_pull_down[k] ? 1'b0 : !pin_o[k];
    end
  end
  assign input_qualify_strobe = ext_stb;
  always_ff @(posedge ref_clk) if (|output_qualify_strobe) seen_word <= pin_i;
endmodule
`default_nettype wire

// >>> bench/tsio_port_top_tb.sv
// Bus-driven tests of the timed serdes port block
`timescale 1ns/1ps
`default_nettype none
module tsio_port_top_tb;
  logic        ref_clk, reset, avs_read, avs_write, avs_waitrequest, ext_pullup, clk_gen;
  logic [7:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, pin_i, pin_o, pin_oe_n, pin_pull_down;
  logic [31:0] ext_val, ext_drv, seen;
  logic [4:0]  iq_stb, oq_stb, port_event, ext_stb;
  int          n_errors, cmp_count;
  logic [31:0] tick_exp [3] = '{32'h190, 32'h64, 32'h32};

  tsio_port_top i_tsio_port_top (
    .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_pull_down(pin_pull_down),
    .input_qualify_strobe(iq_stb), .output_qualify_strobe(oq_stb), .port_event(port_event)
  );
  tsio_ext_model i_tsio_ext_model (
    .ref_clk(ref_clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_pull_down(pin_pull_down),
    .output_qualify_strobe(oq_stb), .pin_i(pin_i), .input_qualify_strobe(iq_stb),
    .ext_val(ext_val), .ext_drv(ext_drv), .ext_stb(ext_stb), .ext_pullup(ext_pullup),
    .clk_gen(clk_gen), .seen_word(seen)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One Avalon access; held until waitrequest is seen low at a rising edge
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 50) begin
      n_errors++;
      results();
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask

  task automatic wait_ev(input int p);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (port_event[p] !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 3000) begin
      n_errors++;
      results();
    end
  endtask

  initial begin
    logic [31:0] q, c1, c2;
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    ext_val = 32'h0;
    ext_drv = 32'h0;
    ext_stb = 5'h0;
    ext_pullup = 1'b0;
    clk_gen = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk("oe_n", pin_oe_n, 32'hFFFFFFFF);
    chk("pull", pin_pull_down, 32'hFFFFFFFF);
    for (int p = 0; p < 5; p++) rchk("ctrl", 8'(p * 32), 32'h0);
    rchk("unmapped", 8'hFC, 32'h0);
    $display("test reset finished");
    // Timed output on the 8-bit port
    acc(1'b1, 8'h40, 32'h3, q);
    acc(1'b1, 8'h4C, 32'h0, q);
    acc(1'b1, 8'h50, 32'h40, q);
    acc(1'b1, 8'h44, 32'hA5, q);
    rchk("armed", 8'h48, 32'h5);
    wait_ev(2);
    chk("out8", pin_o & 32'hFF, 32'hA5);
    chk("drv8", pin_oe_n & 32'hFF, 32'h0);
    rchk("tstamp", 8'h54, 32'h40);
    rchk("stat", 8'h48, 32'h0);
    $display("test timed output finished");
    // Open-drain strobed 4-bit port over the 8-bit one
    ext_pullup <= 1'b1;
    acc(1'b1, 8'h20, 32'h27, q);
    acc(1'b1, 8'h24, 32'h6, q);
    wait_ev(1);
    chk("od_oe", pin_oe_n & 32'hF, 32'h6);
    chk("od_o", pin_o & 32'hF, 32'h0);
    @(negedge ref_clk);
    chk("seen", seen & 32'hFF, 32'hA6);
    acc(1'b1, 8'h20, 32'h0, q);
    acc(1'b1, 8'h40, 32'h0, q);
    ext_pullup <= 1'b0;
    $display("test open drain finished");
    // Conditional input on the 1-bit port, equal then unequal
    ext_drv <= 32'h1;
    acc(1'b1, 8'h18, 32'h1, q);
    for (int m = 1; m < 3; m++) begin
      acc(1'b1, 8'h00, 32'h1 | 32'(m << 3), q);
      ext_val <= (m == 1) ? 32'h0 : 32'h1;
      repeat (8) @(posedge ref_clk);
      acc(1'b0, 8'h04, 32'h0, q);
      repeat (20) @(posedge ref_clk);
      rchk("cond_wait", 8'h08, 32'h0);
      ext_val <= (m == 1) ? 32'h1 : 32'h0;
      wait_ev(0);
      rchk("cond_data", 8'h04, (m == 1) ? 32'h1 : 32'h0);
    end
    acc(1'b1, 8'h00, 32'h0, q);
    $display("test conditional input finished");
    // Strobe-qualified input on the 16-bit port
    ext_drv <= 32'hFFFF;
    ext_val <= 32'h1234;
    acc(1'b1, 8'h60, 32'h21, q);
    repeat (20) @(posedge ref_clk);
    rchk("stb_wait", 8'h68, 32'h0);
    ext_stb <= 5'h08;
    wait_ev(3);
    rchk("stb_data", 8'h64, 32'h1234);
    ext_stb <= 5'h0;
    $display("test strobed input finished");
    // Counter rate from the reference, a divided block and a pin clock
    acc(1'b1, 8'hC4, 32'h3, q);
    acc(1'b1, 8'hC8, 32'h101, q);
    clk_gen <= 1'b1;
    for (int b = 0; b < 3; b++) begin
      acc(1'b1, 8'h60, 32'h1 | 32'(b << 7), q);
      acc(1'b0, 8'h6C, 32'h0, c1);
      repeat (397) @(posedge ref_clk);
      acc(1'b0, 8'h6C, 32'h0, c2);
      chk("ticks", (c2 - c1) & 32'hFFFF, tick_exp[b]);
    end
    clk_gen <= 1'b0;
    ext_drv <= 32'h0;
    acc(1'b1, 8'h60, 32'h0, q);
    $display("test clock blocks finished");
    // Link takes shared pins, then the 32-bit port drives at full width
    acc(1'b1, 8'hA0, 32'h1, q);
    acc(1'b1, 8'h80, 32'h3, q);
    acc(1'b1, 8'h84, 32'hC3A50F96, q);
    repeat (20) @(posedge ref_clk);
    chk("link_oe", pin_oe_n, 32'hFFFFFFFF);
    acc(1'b1, 8'hA0, 32'h0, q);
    wait_ev(4);
    chk("wide_o", pin_o, 32'hC3A50F96);
    chk("wide_oe", pin_oe_n, 32'h0);
    $display("test link finished");
    results();
  end
endmodule
`default_nettype wire
